//--- hdl/sxt_exec.v
// Purpose: Execution of the byte and bit skip tests, the two table reads
//          and the three exclusive-OR operations of an 8-bit core
// Assumes: One clock at the instruction-cycle rate; operands arrive from
//          logic on the same clock; ROM answers one cycle after its request
// Notes: The block owns the working accumulator, the zero flag and the
//        table-high latch; data memory is written through a strobe
//
// Operation
// - A zero byte skips: prefetch dropped, one dummy cycle, two cycles; else one cycle.
// - Load-and-skip copies the byte to the accumulator and skips the same way on zero.
// - The bit skip drops the prefetch and adds a dummy cycle on a clear bit, else one cycle.
// - A taken skip turns the word fetched during execution into a dummy cycle.
// - Current-page table read: ROM word at the pointer, low byte to memory, high to latch.
// - Last-page table read: ROM word at the pointer in the last page, same byte split.
// - Accumulator XOR data byte goes to the accumulator and touches only the zero flag.
// - Data byte XOR accumulator goes back to the data byte and touches only the zero flag.
// - Accumulator XOR the instruction constant goes to the accumulator, zero flag updated.
`timescale 1ns/1ps
`include "sxt_map.vh"

module sxt_exec (
   input wire clock,
   input wire reset_n,
   input wire op_valid,
   output wire op_ready,
   input wire [`SXT_OP_W-1:0] op_code,
   input wire [`SXT_DATA_W-1:0] mem_rdata,
   input wire [`SXT_BIT_SEL_W-1:0] bit_sel,
   input wire [`SXT_DATA_W-1:0] imm_data,
   input wire [`SXT_PAGE_W-1:0] current_page,
   input wire [`SXT_DATA_W-1:0] table_pointer,
   output reg mem_wr_en_q,
   output reg [`SXT_DATA_W-1:0] mem_wdata_q,
   output reg rom_rd_q,
   output reg [`SXT_ROM_ADDR_W-1:0] rom_addr_q,
   input wire [`SXT_ROM_DATA_W-1:0] rom_rdata,
   output reg [`SXT_DATA_W-1:0] working_accumulator_q,
   output reg zero_flag_q,
   output reg [`SXT_DATA_W-1:0] table_high_latch_q,
   output reg discard_prefetch_q,
   output reg done_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Operand tests
   reg [`SXT_ST_W-1:0] state_q;
   reg [`SXT_ST_W-1:0] state_d;
   wire byte_is_zero;
   wire bit_is_clear;
   wire xor_is_zero;
   wire take;
   wire skip_hit;
   wire [`SXT_DATA_W-1:0] xor_mem;
   wire [`SXT_DATA_W-1:0] xor_imm;
   wire [`SXT_PAGE_W-1:0] table_page;

   sxt_zero_test u_mem_test (
      .operand(mem_rdata),
      .bit_sel(bit_sel),
      .byte_is_zero(byte_is_zero),
      .bit_is_clear(bit_is_clear)
   );

   // Each XOR form gets its zero test here from its own XOR result; the memory
   // forms do not use the shared byte test, which only sees mem_rdata.
   assign xor_mem = working_accumulator_q ^ mem_rdata;
   assign xor_imm = working_accumulator_q ^ imm_data;
   assign xor_is_zero = (op_code == `SXT_OP_XOR_IMMEDIATE) ? ~|xor_imm : ~|xor_mem;

   assign op_ready = (state_q == `SXT_ST_IDLE);
   assign take = op_valid & op_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Skip decision
   reg skip_hit_c;

   always @* begin
      case (op_code)
         `SXT_OP_SKIP_BYTE_ZERO: begin
            skip_hit_c = byte_is_zero;
         end
         `SXT_OP_LOAD_SKIP_ZERO: begin
            skip_hit_c = byte_is_zero;
         end
         `SXT_OP_SKIP_BIT_CLEAR: begin
            skip_hit_c = bit_is_clear;
         end
         default: begin
            skip_hit_c = 1'b0;
         end
      endcase
   end

   assign skip_hit = take & skip_hit_c;

   // Page select: current page from the program counter, or the top page
   assign table_page = (op_code == `SXT_OP_TABLE_LAST) ? `SXT_LAST_PAGE : current_page;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always @* begin
      state_d = state_q;
      case (state_q)
         `SXT_ST_IDLE: begin
            if (skip_hit) begin
               state_d = `SXT_ST_DUMMY;
            end else if (take && (op_code == `SXT_OP_TABLE_CURRENT ||
                                  op_code == `SXT_OP_TABLE_LAST)) begin
               state_d = `SXT_ST_TABLE;
            end
         end
         `SXT_ST_DUMMY: begin
            state_d = `SXT_ST_IDLE;
         end
         `SXT_ST_TABLE: begin
            state_d = `SXT_ST_IDLE;
         end
         default: begin
            state_d = `SXT_ST_IDLE;
         end
      endcase
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= `SXT_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pipeline control: dummy cycle and completion
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         discard_prefetch_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         // Prefetched word is squashed for exactly the dummy cycle
         discard_prefetch_q <= skip_hit;
         done_q <= 1'b0;
         case (state_q)
            `SXT_ST_IDLE: begin
               if (take && !skip_hit && op_code != `SXT_OP_TABLE_CURRENT &&
                   op_code != `SXT_OP_TABLE_LAST) begin
                  done_q <= 1'b1;
               end
            end
            `SXT_ST_DUMMY: begin
               done_q <= 1'b1;
            end
            `SXT_ST_TABLE: begin
               done_q <= 1'b1;
            end
            default: begin
               done_q <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program ROM request for the table reads
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rom_rd_q <= 1'b0;
         rom_addr_q <= {`SXT_ROM_ADDR_W{1'b0}};
      end else begin
         rom_rd_q <= 1'b0;
         if (take && (op_code == `SXT_OP_TABLE_CURRENT ||
                      op_code == `SXT_OP_TABLE_LAST)) begin
            rom_rd_q <= 1'b1;
            rom_addr_q <= {table_page, table_pointer};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data memory write strobe
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mem_wr_en_q <= 1'b0;
         mem_wdata_q <= {`SXT_DATA_W{1'b0}};
      end else begin
         mem_wr_en_q <= 1'b0;
         if (state_q == `SXT_ST_TABLE) begin
            // ROM answered one cycle after the request
            mem_wr_en_q <= 1'b1;
            mem_wdata_q <= rom_rdata[`SXT_DATA_W-1:0];
         end else if (take && op_code == `SXT_OP_XOR_TO_MEMORY) begin
            mem_wr_en_q <= 1'b1;
            mem_wdata_q <= xor_mem;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Table-high latch
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         table_high_latch_q <= `SXT_TABLE_HIGH_RESET;
      end else if (state_q == `SXT_ST_TABLE) begin
         table_high_latch_q <= rom_rdata[`SXT_ROM_DATA_W-1:`SXT_DATA_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator and zero flag
   // Table reads and the byte and bit skips leave both untouched; load-and-skip writes the accumulator only; other flags live elsewhere.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         working_accumulator_q <= `SXT_ACCUM_RESET;
         zero_flag_q <= `SXT_ZERO_FLAG_RESET;
      end else if (take) begin
         case (op_code)
            `SXT_OP_LOAD_SKIP_ZERO: begin
               working_accumulator_q <= mem_rdata;
            end
            `SXT_OP_XOR_TO_ACCUM: begin
               working_accumulator_q <= xor_mem;
               zero_flag_q <= xor_is_zero;
            end
            `SXT_OP_XOR_TO_MEMORY: begin
               zero_flag_q <= xor_is_zero;
            end
            `SXT_OP_XOR_IMMEDIATE: begin
               working_accumulator_q <= xor_imm;
               zero_flag_q <= xor_is_zero;
            end
            default: begin
               working_accumulator_q <= working_accumulator_q;
            end
         endcase
      end
   end

endmodule

//--- hdl/sxt_map.vh
// Purpose: Constants for the skip, table-read and exclusive-OR execution unit
// Assumes: Included by bare name from the design files under hdl/
// Notes: Definitions only, no logic
`ifndef SXT_MAP_VH
`define SXT_MAP_VH

// Operation select codes on op_code
`define SXT_OP_W 3
`define SXT_OP_SKIP_BYTE_ZERO 3'h0
`define SXT_OP_LOAD_SKIP_ZERO 3'h1
`define SXT_OP_SKIP_BIT_CLEAR 3'h2
`define SXT_OP_TABLE_CURRENT 3'h3
`define SXT_OP_TABLE_LAST 3'h4
`define SXT_OP_XOR_TO_ACCUM 3'h5
`define SXT_OP_XOR_TO_MEMORY 3'h6
`define SXT_OP_XOR_IMMEDIATE 3'h7

// Data path widths
`define SXT_DATA_W 8
`define SXT_BIT_SEL_W 3
`define SXT_PAGE_W 5
`define SXT_ROM_ADDR_W 13
`define SXT_ROM_DATA_W 16

// Page number of the last program page
`define SXT_LAST_PAGE 5'h1F

// Reset values
`define SXT_ACCUM_RESET 8'h00
`define SXT_ZERO_FLAG_RESET 1'b0
`define SXT_TABLE_HIGH_RESET 8'h00

// Cycle counts of one instruction
`define SXT_CYCLES_NORMAL 1
`define SXT_CYCLES_SKIP 2

// Sequencer state codes
`define SXT_ST_W 2
`define SXT_ST_IDLE 2'h0
`define SXT_ST_DUMMY 2'h1
`define SXT_ST_TABLE 2'h2

`endif

//--- hdl/sxt_zero_test.v
// Purpose: Combinational zero and bit tests on one data byte
// Assumes: Operand is stable for the cycle in which it is read
// Notes: Used only by the skip decisions; the zero flag update has its own XOR-result test
`timescale 1ns/1ps
`include "sxt_map.vh"

module sxt_zero_test (
   input wire [`SXT_DATA_W-1:0] operand,
   input wire [`SXT_BIT_SEL_W-1:0] bit_sel,
   output wire byte_is_zero,
   output wire bit_is_clear
);

   ////////////////////////////////////////////////////////////////////////////
   // Per-bit selection, one decode line per bit
   wire [`SXT_DATA_W-1:0] bit_pick;

   genvar gi;
   generate
      for (gi = 0; gi < `SXT_DATA_W; gi = gi + 1) begin : g_pick
         // Index sized to the select so the compare keeps equal widths
         localparam [`SXT_BIT_SEL_W-1:0] BIT_IDX = gi;
         assign bit_pick[gi] = operand[gi] & (bit_sel == BIT_IDX);
      end
   endgenerate

   assign byte_is_zero = ~|operand;
   assign bit_is_clear = ~|bit_pick;

endmodule

//--- tb/sxt_exec_props.sv
// Purpose: Port-level timing and data checks on the execution unit
// Assumes: One clock domain, reset_n active low
// Notes: Attached by bind from the bench top file
`timescale 1ns/1ps
`include "sxt_map.vh"
module sxt_exec_props (
   input wire clock,
   input wire reset_n,
   input wire op_valid,
   input wire op_ready,
   input wire [2:0] op_code,
   input wire [7:0] mem_rdata,
   input wire [2:0] bit_sel,
   input wire [7:0] imm_data,
   input wire [4:0] current_page,
   input wire [7:0] table_pointer,
   input wire mem_wr_en_q,
   input wire [7:0] mem_wdata_q,
   input wire rom_rd_q,
   input wire [12:0] rom_addr_q,
   input wire [15:0] rom_rdata,
   input wire [7:0] working_accumulator_q,
   input wire zero_flag_q,
   input wire [7:0] table_high_latch_q,
   input wire discard_prefetch_q,
   input wire done_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   wire take = op_valid && op_ready;
   wire [7:0] acc = working_accumulator_q;
   ////////////////////////////////////////////////////////////////////////////////
   property p_skip_zero;
      take && op_code == 3'h0 && mem_rdata == 8'h00 |=> discard_prefetch_q && !done_q ##1 done_q;
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("zero byte skip timing wrong");
   property p_skip_miss;
      take && op_code == 3'h0 && mem_rdata != 8'h00 |=> done_q && !discard_prefetch_q;
   endproperty
   a_skip_miss: assert property (p_skip_miss) else $error("nonzero byte skip wrong");
   property p_load;
      take && op_code == 3'h1 |=> acc == $past(mem_rdata) &&
         discard_prefetch_q == ($past(mem_rdata) == 8'h00);
   endproperty
   a_load: assert property (p_load) else $error("load and skip wrong");
   property p_bit;
      take && op_code == 3'h2 |=> discard_prefetch_q == !$past(mem_rdata[bit_sel]);
   endproperty
   a_bit: assert property (p_bit) else $error("bit skip decision wrong");
   property p_dummy;
      discard_prefetch_q |-> !op_ready ##1 done_q && op_ready;
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy cycle shape wrong");
   property p_tab_addr;
      take && (op_code == 3'h3 || op_code == 3'h4) |=> rom_rd_q &&
         rom_addr_q == {$past(op_code) == 3'h4 ? `SXT_LAST_PAGE : $past(current_page),
         $past(table_pointer)};
   endproperty
   a_tab_addr: assert property (p_tab_addr) else $error("table address wrong");
   property p_tab_data;
      rom_rd_q |=> mem_wr_en_q && done_q && mem_wdata_q == $past(rom_rdata[7:0]) &&
         table_high_latch_q == $past(rom_rdata[15:8]);
   endproperty
   a_tab_data: assert property (p_tab_data) else $error("table data split wrong");
   property p_xor_acc;
      take && (op_code == 3'h5 || op_code == 3'h7) |=> acc == ($past(acc) ^
         ($past(op_code) == 3'h5 ? $past(mem_rdata) : $past(imm_data)));
   endproperty
   a_xor_acc: assert property (p_xor_acc) else $error("accumulator xor wrong");
   property p_xor_mem;
      take && op_code == 3'h6 |=> mem_wr_en_q && $stable(acc) &&
         mem_wdata_q == ($past(acc) ^ $past(mem_rdata));
   endproperty
   a_xor_mem: assert property (p_xor_mem) else $error("memory xor wrong");
   property p_zero;
      take && op_code >= 3'h5 |=>
         zero_flag_q == (($past(op_code) == 3'h6 ? mem_wdata_q : acc) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   c_skip: cover property (take && op_code == 3'h0 && mem_rdata == 8'h00);
   c_table: cover property (rom_rd_q);
   c_xor_mem: cover property (take && op_code == 3'h6);
endmodule

//--- tb/sxt_exec_bench.sv
// Purpose: Directed bench for the skip, table-read and xor execution unit
// Assumes: 20 MHz clock, reset_n held for 5 cycles
// Notes: Bench plays data memory and ROM; released inputs are inverted
`timescale 1ns/1ps
`include "sxt_map.vh"
module sxt_exec_bench;
   reg clock = 1'b0;
   reg reset_n = 1'b0;
   reg op_valid = 1'b0;
   reg [2:0] op_code = 3'h0;
   reg [7:0] mem_rdata = 8'h00;
   reg [2:0] bit_sel = 3'h0;
   reg [7:0] imm_data = 8'h00;
   reg [4:0] current_page = 5'h00;
   reg [7:0] table_pointer = 8'h00;
   reg [15:0] rom_rdata = 16'h0000;
   reg [15:0] rom_next = 16'h0000;
   reg [7:0] acc_e = 8'h00;
   wire op_ready, mem_wr_en_q, rom_rd_q, zero_flag_q, discard_prefetch_q, done_q;
   wire [7:0] mem_wdata_q, working_accumulator_q, table_high_latch_q;
   wire [12:0] rom_addr_q;
   integer n_errors = 0;
   integer compares = 0;
   always #25 clock = ~clock;
   sxt_exec u_dut (
      .clock(clock),
      .reset_n(reset_n),
      .op_valid(op_valid),
      .op_ready(op_ready),
      .op_code(op_code),
      .mem_rdata(mem_rdata),
      .bit_sel(bit_sel),
      .imm_data(imm_data),
      .current_page(current_page),
      .table_pointer(table_pointer),
      .mem_wr_en_q(mem_wr_en_q),
      .mem_wdata_q(mem_wdata_q),
      .rom_rd_q(rom_rd_q),
      .rom_addr_q(rom_addr_q),
      .rom_rdata(rom_rdata),
      .working_accumulator_q(working_accumulator_q),
      .zero_flag_q(zero_flag_q),
      .table_high_latch_q(table_high_latch_q),
      .discard_prefetch_q(discard_prefetch_q),
      .done_q(done_q)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares = compares + 1;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_errors = n_errors + 1;
      end
   endtask
   task tally_and_finish;
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Leaves the bench 1 ns after the take edge, in cycle c1
   task issue(input [2:0] c, input [7:0] m, input [2:0] b, input [7:0] x);
      @(posedge clock);
      op_valid <= 1'b1;
      op_code <= c;
      mem_rdata <= m;
      bit_sel <= b;
      imm_data <= x;
      @(posedge clock);
      op_valid <= 1'b0;
      mem_rdata <= ~m;
      rom_rdata <= rom_next;
      #1;
   endtask
   task t_skip(input [2:0] c, input [7:0] m, input [2:0] b);
      reg hit;
      hit = (c == 3'h2) ? !m[b] : (m == 8'h00);
      if (c == 3'h1) acc_e = m;
      issue(c, m, b, 8'h00);
      chk("discard", hit, discard_prefetch_q);
      chk("done", !hit, done_q);
      chk("acc", acc_e, working_accumulator_q);
      if (hit) begin
         chk("ready", 1'b0, op_ready);
         @(posedge clock);
         #1;
         chk("done", 1'b1, done_q);
      end
   endtask
   task t_xor(input [2:0] c, input [7:0] m, input [7:0] x);
      reg [7:0] r;
      r = acc_e ^ ((c == 3'h7) ? x : m);
      issue(c, m, 3'h0, x);
      if (c == 3'h6) begin
         chk("wdata", r, mem_wdata_q);
         chk("wr_en", 1'b1, mem_wr_en_q);
      end else
         acc_e = r;
      chk("acc", acc_e, working_accumulator_q);
      chk("zero", r == 8'h00, zero_flag_q);
      chk("done", 1'b1, done_q);
   endtask
   task t_table(input [2:0] c, input [4:0] pg, input [7:0] p, input [15:0] w);
      @(posedge clock);
      current_page <= pg;
      table_pointer <= p;
      rom_next = w;
      issue(c, 8'h00, 3'h0, 8'h00);
      rom_next = ~w;
      chk("rom_rd", 1'b1, rom_rd_q);
      chk("rom_addr", {(c == 3'h4) ? `SXT_LAST_PAGE : pg, p}, rom_addr_q);
      chk("ready", 1'b0, op_ready);
      chk("done", 1'b0, done_q);
      @(posedge clock);
      rom_rdata <= ~w;
      #1;
      chk("low", w[7:0], mem_wdata_q);
      chk("high", w[15:8], table_high_latch_q);
      chk("wr_en", 1'b1, mem_wr_en_q);
      chk("done", 1'b1, done_q);
      chk("acc", acc_e, working_accumulator_q);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      #1;
      chk("acc", 8'h00, working_accumulator_q);
      chk("latch", 8'h00, table_high_latch_q);
      chk("ready", 1'b1, op_ready);
      t_skip(3'h0, 8'h00, 3'h0);
      t_skip(3'h0, 8'h80, 3'h0);
      t_skip(3'h1, 8'h00, 3'h0);
      t_skip(3'h1, 8'h3C, 3'h0);
      t_skip(3'h2, 8'h7F, 3'h7);
      t_skip(3'h2, 8'h80, 3'h7);
      t_skip(3'h2, 8'hFE, 3'h0);
      t_xor(3'h5, 8'hA5, 8'h00);
      t_xor(3'h7, 8'h00, 8'h99);
      t_xor(3'h6, 8'h5A, 8'h00);
      t_xor(3'h6, 8'h00, 8'h00);
      t_xor(3'h7, 8'h00, 8'h81);
      t_table(3'h3, 5'h0A, 8'hC3, 16'hA55A);
      t_table(3'h4, 5'h03, 8'h7E, 16'h8001);
      tally_and_finish;
   end
   // Whole sequence needs well under 100 cycles
   initial begin
      #20000;
      n_errors = n_errors + 1;
      tally_and_finish;
   end
endmodule
bind sxt_exec sxt_exec_props u_props (
   .clock(clock),
   .reset_n(reset_n),
   .op_valid(op_valid),
   .op_ready(op_ready),
   .op_code(op_code),
   .mem_rdata(mem_rdata),
   .bit_sel(bit_sel),
   .imm_data(imm_data),
   .current_page(current_page),
   .table_pointer(table_pointer),
   .mem_wr_en_q(mem_wr_en_q),
   .mem_wdata_q(mem_wdata_q),
   .rom_rd_q(rom_rd_q),
   .rom_addr_q(rom_addr_q),
   .rom_rdata(rom_rdata),
   .working_accumulator_q(working_accumulator_q),
   .zero_flag_q(zero_flag_q),
   .table_high_latch_q(table_high_latch_q),
   .discard_prefetch_q(discard_prefetch_q),
   .done_q(done_q)
);
